// ===== hw/cht_defs.svh
/*
  Register offsets, field positions, reset values for the codec host port.
  Assumes inclusion by bare name from files under hw/ and verification/.
*/
`ifndef CHT_DEFS_SVH
`define CHT_DEFS_SVH

// Direct register selects
`define CHT_SEL_INDEX    2'h0
`define CHT_SEL_DATA     2'h1
`define CHT_SEL_STATUS   2'h2
`define CHT_SEL_PIO      2'h3

// Indexed register numbers
`define CHT_IDX_FORMAT   4'h8
`define CHT_IDX_CONFIG   4'h9
`define CHT_IDX_PIN      4'ha
`define CHT_IDX_UPPER    4'he
`define CHT_IDX_LOWER    4'hf

// Field positions
`define CHT_CFG_PB_ON    0
`define CHT_CFG_CAP_ON   1
`define CHT_CFG_SINGLE   2
`define CHT_CFG_PB_PIO   6
`define CHT_CFG_CAP_PIO  7
`define CHT_FMT_STEREO   4
`define CHT_FMT_WIDE     6
`define CHT_PIN_IRQ_GATE 1
`define CHT_PIN_XCTL_LO  6
`define CHT_IDX_HALT     5
`define CHT_IDX_WINDOW   6
`define CHT_STAT_IRQ     0
`define CHT_STAT_PB_RDY  1
`define CHT_STAT_CAP_RDY 5

// Reset values
`define CHT_CONFIG_RESET 8'h08
`define CHT_REG_RESET    8'h00
`define CHT_COUNT_RESET  16'h0000

`endif

// ===== hw/cht_pkg.sv
/*
  Types shared by the codec host port and its sample slot.
  Assumes no other package is needed.
*/
package cht_pkg;

  // Host bus pins, sampled synchronous to ref_clk
  typedef struct packed {
    logic [1:0] register_select;
    logic       chip_select_n;
    logic       read_strobe_n;
    logic       store_strobe_n;
    logic       capture_ack_n;
    logic       playback_ack_n;
    logic [7:0] data;
  } cht_host_bus_type;

  // Kind of host cycle seen at a strobe's falling edge
  typedef enum logic [1:0] {
    CYC_NONE,
    CYC_REG,
    CYC_PB_DMA,
    CYC_CAP_DMA
  } cht_cycle_type;

endpackage : cht_pkg

// ===== hw/cht_sample_slot.sv
/*
  One-sample holding register moved byte by byte, in transfer order.
  Assumes the caller never puts and takes in the same cycle.
*/
module cht_sample_slot (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Sample shape
  input  wire logic [2:0]  byte_total,
  // Whole-sample side
  input  wire logic        fill,
  input  wire logic [31:0] fill_word,
  input  wire logic        drain,
  // Byte side
  input  wire logic        put,
  input  wire logic [7:0]  put_byte,
  input  wire logic        take,
  // State
  output logic             full,
  output logic             last,
  output logic [31:0]      word,
  output logic [7:0]       cur_byte
);
  import cht_pkg::*;

  logic [1:0]  idx;
  logic [1:0]  next_idx;
  logic        next_full;
  logic [31:0] next_word;

  assign last     = ({1'b0, idx} == byte_total - 3'h1);
  assign cur_byte = word[{idx, 3'h0} +: 8];

  ////////////////////////////////////////////////////////////////
  // Byte walk; byte index 0 is the first moved
  always_comb begin
    next_idx  = idx;
    next_full = full;
    next_word = word;
    if (drain) begin
      next_full = 1'b0;
      next_idx  = 2'h0;
    end
    if (fill) begin
      next_word = fill_word;
      next_full = 1'b1;
      next_idx  = 2'h0;
    end
    if (put && !full) begin
      next_word[{idx, 3'h0} +: 8] = put_byte;
      next_full = last;
      next_idx  = last ? 2'h0 : idx + 2'h1;
    end
    if (take && full) begin
      next_full = !last;
      next_idx  = last ? 2'h0 : idx + 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      idx  <= 2'h0;
      full <= 1'b0;
      word <= 32'h0000_0000;
    end else begin
      idx  <= next_idx;
      full <= next_full;
      word <= next_word;
    end
  end

endmodule : cht_sample_slot

// ===== hw/cht_host_port.sv
/*
  Byte-wide host port of a stereo codec: control registers, PIO and DMA
  sample moves, base/current sample count and the count interrupt.
  Assumes host pins are synchronous to ref_clk and that the converter
  pulses period_start early and capture_point late in each sample period.
*/
// Notes on behaviour
// - Lower base byte is 8 bits, resets zero, reads back; current count unreadable.
// - Sixteen-bit words move low byte first, then high byte.
// - Left channel bytes always move before right channel bytes.
// - One sample held per direction; no FIFO.
// - Control and PIO registers reached only by strobes, never by acknowledges.
// - PIO per direction active only with its enable and its PIO bit set.
// - Read data driven while read strobe is low.
// - Host drives data while store strobe low; byte taken at its rising edge.
// - External control pins follow their bits at the sample period mark.
// - DMA per direction needs its enable set and its PIO bit clear.
// - Requests answered by acknowledges; select and chip select then ignored.
// - Playback requests early in the period, capture late.
// - Request holds until the final byte strobe of the sample falls.
// - Clearing an enable ends the direction only after the pending sample.
// - Single-channel mode: capture uses playback request and acknowledge.
// - Single-channel mode with both enables behaves as playback.
// - Single-channel switching needs only enable toggles after PIO bits cleared.
// - Interrupt pin rises in the period the count underflows.
// - One direction may use PIO while the other uses DMA.
// - Upper byte write loads count; decrement; underflow raises interrupt, reloads.
// - Count decrements with an enable on and halt or status bit clear.
// - Status bit sets regardless of gate; pin gated; status write clears.
`include "cht_defs.svh"

module cht_host_port (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      reset,
  // Host bus
  input  wire cht_pkg::cht_host_bus_type host_in,
  output logic [7:0]                     data_out,
  output logic                           data_oe,
  output logic                           playback_request,
  output logic                           capture_request,
  output logic                           host_irq_line,
  output logic [1:0]                     external_control_outputs,
  // Converter side
  input  wire logic                      period_start,
  input  wire logic                      capture_point,
  input  wire logic [31:0]               capture_word,
  output logic [31:0]                    playback_word,
  output logic                           playback_word_valid
);
  import cht_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]    ctrl_file [16];
  logic [7:0]    next_ctrl_file [16];
  logic [7:0]    index_reg;
  logic [7:0]    next_index_reg;
  logic          prev_rd_n;
  logic          prev_wr_n;
  logic [7:0]    wr_byte;
  logic [7:0]    next_wr_byte;
  cht_cycle_type wr_kind;
  cht_cycle_type next_wr_kind;
  logic [1:0]    wr_sel;
  logic [1:0]    next_wr_sel;
  logic          next_data_oe;
  logic [7:0]    next_data_out;
  logic          pb_req;
  logic          next_pb_req;
  logic          cap_req;
  logic          next_cap_req;
  logic [15:0]   cur_count;
  logic [15:0]   next_cur_count;
  logic          irq_status;
  logic          next_irq_status;
  logic          next_irq_line;
  logic [1:0]    next_xctl;
  logic [31:0]   next_pb_word;
  logic          next_pb_valid;
  cht_cycle_type kind;
  logic          rd_fall;
  logic          wr_fall;
  logic          wr_rise;
  logic [3:0]    index;
  logic          pb_on;
  logic          cap_on;
  logic          single;
  logic          pb_pio;
  logic          cap_pio;
  logic          pb_dma;
  logic          cap_dma;
  logic [2:0]    byte_total;
  logic          reg_write;
  logic          pb_put;
  logic          cap_take;
  logic          pb_drain;
  logic          cap_fill;
  logic          pb_full;
  logic          pb_last;
  logic          cap_full;
  logic          cap_last;
  logic [31:0]   pb_slot_word;
  logic [7:0]    cap_byte;
  logic [7:0]    status_byte;

  ////////////////////////////////////////////////////////////////
  // Mode decode from the configuration and format registers
  assign index   = index_reg[3:0];
  assign pb_on   = ctrl_file[`CHT_IDX_CONFIG][`CHT_CFG_PB_ON];
  assign cap_on  = ctrl_file[`CHT_IDX_CONFIG][`CHT_CFG_CAP_ON];
  assign single  = ctrl_file[`CHT_IDX_CONFIG][`CHT_CFG_SINGLE];
  // PIO needs enable and PIO bit; set per direction
  assign pb_pio  = pb_on && ctrl_file[`CHT_IDX_CONFIG][`CHT_CFG_PB_PIO];
  assign cap_pio = cap_on && ctrl_file[`CHT_IDX_CONFIG][`CHT_CFG_CAP_PIO];
  // DMA needs enable with PIO bit clear
  // Both PIO bits clear: direction follows enables and the single bit
  assign pb_dma  = pb_on && !ctrl_file[`CHT_IDX_CONFIG][`CHT_CFG_PB_PIO];
  // Single channel with both enables presumes playback
  assign cap_dma = cap_on && !ctrl_file[`CHT_IDX_CONFIG][`CHT_CFG_CAP_PIO]
                   && !(single && pb_on);

  // Bytes per sample from mono/stereo and 8/16 bit
  always_comb begin
    unique case ({ctrl_file[`CHT_IDX_FORMAT][`CHT_FMT_WIDE],
                  ctrl_file[`CHT_IDX_FORMAT][`CHT_FMT_STEREO]})
      2'b00:   byte_total = 3'h1;
      2'b01:   byte_total = 3'h2;
      2'b10:   byte_total = 3'h2;
      2'b11:   byte_total = 3'h4;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Strobe edges; pins are already in the ref_clk domain
  assign rd_fall = prev_rd_n && !host_in.read_strobe_n;
  assign wr_fall = prev_wr_n && !host_in.store_strobe_n;
  assign wr_rise = !prev_wr_n && host_in.store_strobe_n;

  // Acknowledged cycles ignore select and chip select
  // In single-channel mode the playback ack may carry capture
  always_comb begin
    if (!host_in.playback_ack_n) begin
      kind = (single && cap_req && !pb_req) ? CYC_CAP_DMA : CYC_PB_DMA;
    end else if (!host_in.capture_ack_n && !single) begin
      kind = CYC_CAP_DMA;
    end else if (!host_in.chip_select_n) begin
      kind = CYC_REG;
    end else begin
      kind = CYC_NONE;
    end
  end

  assign status_byte = {2'b00, cap_on && cap_full, 3'b000,
                        pb_on && !pb_full, irq_status};
  assign reg_write   = wr_rise && (wr_kind == CYC_REG);

  ////////////////////////////////////////////////////////////////
  // Slot control: put at store rising edge, take at read falling edge
  // Byte latched while strobe low, committed at rising edge
  assign pb_put   = wr_rise && ((wr_kind == CYC_PB_DMA) ||
                    (wr_kind == CYC_REG && wr_sel == `CHT_SEL_PIO && pb_pio));
  assign cap_take = rd_fall && ((kind == CYC_CAP_DMA) ||
                    (kind == CYC_REG && host_in.register_select == `CHT_SEL_PIO
                     && cap_pio));
  // Capture only into an empty slot; a late reader loses the new one
  assign cap_fill = capture_point && cap_on && !cap_full;
  assign pb_drain = period_start && pb_on && pb_full;

  cht_sample_slot u_pb_slot (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .byte_total(byte_total),
    .fill      (1'b0),
    .fill_word (32'h0000_0000),
    .drain     (pb_drain),
    .put       (pb_put),
    .put_byte  (wr_byte),
    .take      (1'b0),
    .full      (pb_full),
    .last      (pb_last),
    .word      (pb_slot_word),
    .cur_byte  ()
  );

  cht_sample_slot u_cap_slot (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .byte_total(byte_total),
    .fill      (cap_fill),
    .fill_word (capture_word),
    .drain     (1'b0),
    .put       (1'b0),
    .put_byte  (8'h00),
    .take      (cap_take),
    .full      (cap_full),
    .last      (cap_last),
    .word      (),
    .cur_byte  (cap_byte)
  );

  ////////////////////////////////////////////////////////////////
  // Host cycle tracking and register file
  always_comb begin
    next_ctrl_file = ctrl_file;
    next_index_reg = index_reg;
    next_wr_byte   = host_in.store_strobe_n ? wr_byte : host_in.data;
    next_wr_kind   = wr_fall ? kind : wr_kind;
    next_wr_sel    = wr_fall ? host_in.register_select : wr_sel;
    next_data_oe   = data_oe;
    next_data_out  = data_out;
    if (reg_write) begin
      unique case (wr_sel)
        `CHT_SEL_INDEX: next_index_reg = wr_byte;
        // Base bytes store and read back as written
        `CHT_SEL_DATA:  next_ctrl_file[index] = wr_byte;
        default:        next_index_reg = index_reg;
      endcase
    end
    // Drive from read falling edge until the strobe rises
    if (rd_fall && kind != CYC_NONE) begin
      next_data_oe = 1'b1;
      if (kind == CYC_CAP_DMA) begin
        next_data_out = cap_byte;
      end else if (kind == CYC_PB_DMA) begin
        next_data_out = 8'h00;
      end else begin
        unique case (host_in.register_select)
          `CHT_SEL_INDEX:  next_data_out = index_reg;
          `CHT_SEL_DATA:   next_data_out = ctrl_file[index];
          `CHT_SEL_STATUS: next_data_out = status_byte;
          `CHT_SEL_PIO:    next_data_out = cap_pio ? cap_byte : 8'h00;
        endcase
      end
    end
    if (host_in.read_strobe_n) begin
      next_data_oe = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        ctrl_file[i] <= `CHT_REG_RESET;
      end
      ctrl_file[`CHT_IDX_CONFIG] <= `CHT_CONFIG_RESET;
      index_reg <= `CHT_REG_RESET;
      prev_rd_n <= 1'b1;
      prev_wr_n <= 1'b1;
      wr_byte   <= 8'h00;
      wr_kind   <= CYC_NONE;
      wr_sel    <= 2'h0;
      data_oe   <= 1'b0;
      data_out  <= 8'h00;
    end else begin
      ctrl_file <= next_ctrl_file;
      index_reg <= next_index_reg;
      prev_rd_n <= host_in.read_strobe_n;
      prev_wr_n <= host_in.store_strobe_n;
      wr_byte   <= next_wr_byte;
      wr_kind   <= next_wr_kind;
      wr_sel    <= next_wr_sel;
      data_oe   <= next_data_oe;
      data_out  <= next_data_out;
    end
  end

  ////////////////////////////////////////////////////////////////
  // DMA requests; clearing an enable never drops a raised request
  always_comb begin
    next_pb_req  = pb_req;
    next_cap_req = cap_req;
    // Drop after falling edge of the final byte strobe
    if (wr_fall && kind == CYC_PB_DMA && pb_last && !pb_full) begin
      next_pb_req = 1'b0;
    end
    if (rd_fall && kind == CYC_CAP_DMA && cap_last && cap_full) begin
      next_cap_req = 1'b0;
    end
    // Playback early in the period, capture late
    // New requests only while enabled; pending ones stay
    if (period_start && pb_dma) begin
      next_pb_req = 1'b1;
    end
    if (cap_fill && cap_dma) begin
      next_cap_req = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pb_req  <= 1'b0;
      cap_req <= 1'b0;
    end else begin
      pb_req  <= next_pb_req;
      cap_req <= next_cap_req;
    end
  end

  // Single-channel routes capture onto the playback pin
  assign playback_request = pb_req || (single && cap_req);
  assign capture_request  = cap_req && !single;

  ////////////////////////////////////////////////////////////////
  // Sample count, interrupt, external pins, playback hand-off
  always_comb begin
    next_cur_count  = cur_count;
    next_irq_status = irq_status;
    next_xctl       = external_control_outputs;
    next_pb_word    = playback_word;
    next_pb_valid   = pb_drain;
    if (pb_drain) begin
      next_pb_word = pb_slot_word;
    end
    // Status write clears; a same-cycle underflow still sets
    if (reg_write && wr_sel == `CHT_SEL_STATUS) begin
      next_irq_status = 1'b0;
    end
    if (period_start) begin
      // External pins move on the sample period mark
      next_xctl = ctrl_file[`CHT_IDX_PIN][`CHT_PIN_XCTL_LO +: 2];
      // Decrement gate, both PIO and DMA
      if ((pb_on || cap_on) &&
          (!index_reg[`CHT_IDX_HALT] || !irq_status)) begin
        // Period after zero: interrupt and reload
        if (cur_count == `CHT_COUNT_RESET) begin
          next_irq_status = 1'b1;
          next_cur_count  = {ctrl_file[`CHT_IDX_UPPER],
                             ctrl_file[`CHT_IDX_LOWER]};
        end else begin
          next_cur_count = cur_count - 16'h0001;
        end
      end
    end
    // Upper byte write loads the whole base
    if (reg_write && wr_sel == `CHT_SEL_DATA && index == `CHT_IDX_UPPER) begin
      next_cur_count = {wr_byte, ctrl_file[`CHT_IDX_LOWER]};
    end
  end

  // Pin follows the gated status bit
  assign next_irq_line = next_irq_status &&
                         ctrl_file[`CHT_IDX_PIN][`CHT_PIN_IRQ_GATE];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cur_count                <= `CHT_COUNT_RESET;
      irq_status               <= 1'b0;
      host_irq_line            <= 1'b0;
      external_control_outputs <= 2'b00;
      playback_word            <= 32'h0000_0000;
      playback_word_valid      <= 1'b0;
    end else begin
      cur_count                <= next_cur_count;
      irq_status               <= next_irq_status;
      host_irq_line            <= next_irq_line;
      external_control_outputs <= next_xctl;
      playback_word            <= next_pb_word;
      playback_word_valid      <= next_pb_valid;
    end
  end

endmodule : cht_host_port

// ===== verification/cht_host_port_sva.sv
/*
  Pin checker for the codec host port.
  Assumes it is bound to cht_host_port with one clock and a sync reset.
*/
module cht_host_port_sva (
  // Clock and reset
  input wire logic                      ref_clk,
  input wire logic                      reset,
  // Host side pins
  input wire cht_pkg::cht_host_bus_type host_in,
  input wire logic                      data_oe,
  input wire logic                      playback_request,
  input wire logic                      capture_request,
  input wire logic                      host_irq_line,
  input wire logic [1:0]                external_control_outputs,
  // Converter side pins
  input wire logic                      period_start,
  input wire logic                      capture_point,
  input wire logic                      playback_word_valid
);
  import cht_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic acks_hi;
  // Register cycle only while both acknowledges are idle
  assign acks_hi = host_in.capture_ack_n && host_in.playback_ack_n;
  ////////////////////////////////////////////////////////////////////////////
  oe_strobe_a: assert property (data_oe |-> $past(!host_in.read_strobe_n))
    else $error("data bus driven without read strobe");
  oe_reg_a: assert property (
    $fell(host_in.read_strobe_n) && !host_in.chip_select_n && acks_hi |=> data_oe)
    else $error("register read not driven");
  oe_refuse_a: assert property (
    $fell(host_in.read_strobe_n) && host_in.chip_select_n && acks_hi |=> !data_oe)
    else $error("unselected read drove the bus");
  pb_hold_a: assert property (
    playback_request && host_in.playback_ack_n |=> playback_request)
    else $error("playback request dropped unserved");
  cap_hold_a: assert property (
    capture_request && host_in.capture_ack_n |=> capture_request)
    else $error("capture request dropped unserved");
  pb_cause_a: assert property (
    $rose(playback_request) |-> $past(period_start) || $past(capture_point))
    else $error("playback request without period mark");
  cap_cause_a: assert property ($rose(capture_request) |-> $past(capture_point))
    else $error("capture request without capture point");
  irq_rise_a: assert property ($rose(host_irq_line) |-> $past(period_start))
    else $error("interrupt rose off the period mark");
  xctl_sync_a: assert property (
    !$stable(external_control_outputs) |-> $past(period_start))
    else $error("control pins moved off the period mark");
  word_mark_a: assert property (playback_word_valid |-> $past(period_start))
    else $error("playback word off the period mark");
  // Main scenarios reached
  cover property (playback_word_valid);
  cover property ($rose(host_irq_line));
  cover property ($fell(playback_request));
  cover property ($fell(capture_request));
endmodule : cht_host_port_sva

bind cht_host_port cht_host_port_sva chk (.*);

// ===== verification/cht_host_model.sv
/*
  Host CPU and DMA controller model for the codec host bus.
  Assumes the bench calls its tasks by hierarchy; drives at falling edges.
*/
module cht_host_model (
  // Clock
  input wire logic                  ref_clk,
  // Device drive of the data wire
  input wire logic [7:0]            data_out,
  input wire logic                  data_oe,
  // Host bus
  output cht_pkg::cht_host_bus_type host_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import cht_pkg::*;
  cht_host_bus_type b = '{2'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00};
  // Wire level: device drive wins while its enable is high
  always_comb begin
    host_in = b;
    if (data_oe) host_in.data = data_out;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Released data keeps toggling so a stale byte never reads as good
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      b.data = ~b.data;
    end
  endtask : idle
  // select low, acknowledges high, byte held while store low
  task automatic reg_wr(input logic [1:0] sel, input logic [7:0] v);
    @(negedge ref_clk);
    b.chip_select_n = 1'b0;
    b.register_select = sel;
    b.store_strobe_n = 1'b0;
    b.data = v;
    @(negedge ref_clk);
    b.store_strobe_n = 1'b1;
    b.chip_select_n = 1'b1;
    idle(2);
  endtask : reg_wr
  // read strobe held until the byte is taken
  task automatic reg_rd(input logic [1:0] sel, input logic cs_n, output logic [31:0] v);
    @(negedge ref_clk);
    b.chip_select_n = cs_n;
    b.register_select = sel;
    b.read_strobe_n = 1'b0;
    idle(2);
    v = {24'h00_0000, host_in.data};
    b.read_strobe_n = 1'b1;
    b.chip_select_n = 1'b1;
    idle(2);
  endtask : reg_rd
  // acknowledged bytes; select and chip select left wrong on purpose
  task automatic dma(input logic rd, input logic cap, input int nb,
                     input logic [31:0] wv, output logic [31:0] rv);
    rv = '0;
    @(negedge ref_clk);
    b.register_select = 2'h2;
    b.capture_ack_n = !cap;
    b.playback_ack_n = cap;
    for (int i = 0; i < nb; i++) begin
      b.read_strobe_n = !rd;
      b.store_strobe_n = rd;
      b.data = wv[8*i +: 8];
      @(negedge ref_clk);
      @(negedge ref_clk);
      rv[8*i +: 8] = host_in.data;
      b.read_strobe_n = 1'b1;
      b.store_strobe_n = 1'b1;
      idle(1);
    end
    b.capture_ack_n = 1'b1;
    b.playback_ack_n = 1'b1;
    idle(1);
  endtask : dma
endmodule : cht_host_model

// ===== verification/testbench.sv
/*
  Self-checking bench for the codec host port: registers, PIO, DMA, count.
  Assumes the host model drives the bus and the bench plays the converter.
*/
`include "cht_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cht_pkg::*;
  logic             ref_clk, reset, period_start, capture_point, data_oe;
  logic             playback_request, capture_request, host_irq_line, playback_word_valid;
  logic [7:0]       data_out;
  logic [1:0]       external_control_outputs;
  logic [31:0]      capture_word, playback_word, rd, rv;
  cht_host_bus_type host_in;
  int               error_cnt = 0;
  int               num_checks = 0;
  cht_host_model host (.ref_clk(ref_clk), .data_out(data_out), .data_oe(data_oe),
    .host_in(host_in));
  cht_host_port dut (.*);
  ////////////////////////////////////////////////////////////////////////////
  // Compares and verdict
  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_val(n, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask : chk_bit
  task automatic finish_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  // Indexed access goes through the index select then the data select
  task automatic iw(input logic [3:0] idx, input logic [7:0] v);
    host.reg_wr(`CHT_SEL_INDEX, {4'h0, idx});
    host.reg_wr(`CHT_SEL_DATA, v);
  endtask : iw
  task automatic ir(input logic [3:0] idx, output logic [31:0] v);
    host.reg_wr(`CHT_SEL_INDEX, {4'h0, idx});
    host.reg_rd(`CHT_SEL_DATA, 1'b0, v);
  endtask : ir
  // Converter marks last one cycle
  task automatic pulse(input logic ps, input logic cp);
    @(negedge ref_clk);
    period_start = ps;
    capture_point = cp;
    @(negedge ref_clk);
    period_start = 1'b0;
    capture_point = 1'b0;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("MISMATCH watchdog expected end seen hang");
    finish_test();
  end
  // Main sequence
  initial begin
    reset = 1'b1;
    period_start = 1'b0;
    capture_point = 1'b0;
    capture_word = '0;
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
    ir(`CHT_IDX_LOWER, rd);
    chk_val("lower_reset", {24'h00_0000, `CHT_REG_RESET}, rd);
    ir(`CHT_IDX_CONFIG, rd);
    chk_val("config_reset", {24'h00_0000, `CHT_CONFIG_RESET}, rd);
    iw(`CHT_IDX_LOWER, 8'h5a);
    ir(`CHT_IDX_LOWER, rd);
    chk_val("lower_back", 32'h0000_005a, rd);
    host.reg_rd(`CHT_SEL_STATUS, 1'b1, rd);
    // PIO both ways, 16-bit stereo
    iw(`CHT_IDX_FORMAT, 8'h50);
    iw(`CHT_IDX_CONFIG, 8'hc3);
    capture_word = 32'h4433_2211;
    pulse(1'b0, 1'b1);
    host.reg_rd(`CHT_SEL_STATUS, 1'b0, rd);
    chk_val("status_ready", 32'h0000_0022, rd);
    for (int i = 0; i < 4; i++) begin
      host.reg_rd(`CHT_SEL_PIO, 1'b0, rd);
      chk_val("pio_capture", {24'h00_0000, capture_word[8*i +: 8]}, rd);
      host.reg_wr(`CHT_SEL_PIO, 8'(32'hd4c3_b2a1 >> (8*i)));
    end
    pulse(1'b1, 1'b0);
    chk_bit("pb_valid", 1'b1, playback_word_valid);
    chk_val("pb_word", 32'hd4c3_b2a1, playback_word);
    host.reg_rd(`CHT_SEL_STATUS, 1'b0, rd);
    chk_val("irq_status", 32'h0000_0003, rd);
    chk_bit("irq_gated", 1'b0, host_irq_line);
    host.reg_wr(`CHT_SEL_STATUS, 8'h00);
    // Playback DMA beside capture PIO, then abort with a request pending
    iw(`CHT_IDX_FORMAT, 8'h10);
    iw(`CHT_IDX_CONFIG, 8'h83);
    pulse(1'b1, 1'b0);
    chk_bit("pb_req", 1'b1, playback_request);
    host.dma(1'b0, 1'b0, 1, 32'h0000_00aa, rv);
    chk_bit("pb_req_mid", 1'b1, playback_request);
    host.dma(1'b0, 1'b0, 1, 32'h0000_00bb, rv);
    chk_bit("pb_req_done", 1'b0, playback_request);
    pulse(1'b1, 1'b0);
    chk_val("pb_stereo", 32'h0000_bbaa, {16'h0000, playback_word[15:0]});
    iw(`CHT_IDX_CONFIG, 8'h82);
    chk_bit("abort_hold", 1'b1, playback_request);
    host.dma(1'b0, 1'b0, 2, 32'h0000_2211, rv);
    pulse(1'b1, 1'b0);
    chk_bit("abort_done", 1'b0, playback_request);
    // Capture DMA, 16-bit mono
    iw(`CHT_IDX_FORMAT, 8'h40);
    iw(`CHT_IDX_CONFIG, 8'h02);
    capture_word = 32'h0000_beef;
    pulse(1'b0, 1'b1);
    chk_bit("cap_req", 1'b1, capture_request);
    host.dma(1'b1, 1'b1, 2, '1, rv);
    chk_val("cap_dma", 32'h0000_beef, {16'h0000, rv[15:0]});
    chk_bit("cap_req_done", 1'b0, capture_request);
    // Single channel: capture on the playback pins, then both enables
    iw(`CHT_IDX_CONFIG, 8'h00);
    iw(`CHT_IDX_FORMAT, 8'h00);
    iw(`CHT_IDX_CONFIG, 8'h06);
    capture_word = 32'h0000_0077;
    pulse(1'b0, 1'b1);
    chk_bit("single_cap_pin", 1'b0, capture_request);
    chk_bit("single_pb_pin", 1'b1, playback_request);
    host.dma(1'b1, 1'b0, 1, '1, rv);
    chk_val("single_cap", 32'h0000_0077, {24'h00_0000, rv[7:0]});
    iw(`CHT_IDX_CONFIG, 8'h00);
    iw(`CHT_IDX_CONFIG, 8'h07);
    pulse(1'b0, 1'b1);
    chk_bit("both_cap", 1'b0, playback_request);
    pulse(1'b1, 1'b0);
    chk_bit("both_pb", 1'b1, playback_request);
    host.dma(1'b0, 1'b0, 1, 32'h0000_005c, rv);
    pulse(1'b1, 1'b0);
    chk_val("single_pb", 32'h0000_005c, {24'h00_0000, playback_word[7:0]});
    // Count, interrupt and control pins
    iw(`CHT_IDX_PIN, 8'h82);
    chk_val("xctl_wait", 32'h0000_0000, {30'h0000_0000, external_control_outputs});
    iw(`CHT_IDX_LOWER, 8'h02);
    iw(`CHT_IDX_UPPER, 8'h00);
    iw(`CHT_IDX_CONFIG, 8'h41);
    for (int i = 0; i < 3; i++) begin
      pulse(1'b1, 1'b0);
      chk_bit("irq_line", i == 2, host_irq_line);
    end
    chk_val("xctl_pins", 32'h0000_0002, {30'h0000_0000, external_control_outputs});
    host.reg_wr(`CHT_SEL_STATUS, 8'h00);
    chk_bit("irq_clear", 1'b0, host_irq_line);
    finish_test();
  end
endmodule : testbench
